/* include/mfd_pkg.sv */
// Functional notes
// - split the 24-bit word into fields of 3, 4, 5, 4, 4, 4 bits.
// - subtract drives mode low, func 0 low, func 1-2 high, func 3 low, carry-in low.
// - store code Q raises Q parallel-mode select and Q load strobe together.
// - store code F raises F parallel-mode select and F load strobe together.
// - reverse-skip special code inverts the skip condition of the same word.
// - skip codes drop the next word on sign bit, carry out, or always; the skip flop holds the skip only while no word waits.
// - jump function suppresses the special-field and skip-field actions.
// - jump loads the ROM address register from the special field.
package mfd_pkg;

  // ---------------------------------------------------------------
  // field layout of the microword, most significant field first
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int RBUS_W = 3;
  localparam int SBUS_W = 4;
  localparam int FUNC_W = 5;
  localparam int STORE_W = 4;
  localparam int SPEC_W = 4;
  localparam int SKIP_W = 4;
  localparam int RBUS_LSB = 21;
  localparam int SBUS_LSB = 17;
  localparam int FUNC_LSB = 12;
  localparam int STORE_LSB = 8;
  localparam int SPEC_LSB = 4;
  localparam int SKIP_LSB = 0;

  // ---------------------------------------------------------------
  // field codes
  // ---------------------------------------------------------------
  localparam logic [2:0] RBUS_NOP = 3'h7;
  localparam logic [3:0] SBUS_SP1 = 4'hb;
  localparam logic [3:0] SBUS_SP2 = 4'ha;
  localparam logic [3:0] SBUS_SP3 = 4'h9;
  localparam logic [4:0] FUNC_SUB = 5'h05;
  localparam logic [4:0] FUNC_NOR = 5'h0d;
  localparam logic [4:0] FUNC_JMP = 5'h12;
  localparam logic [4:0] FUNC_IOR = 5'h1f;
  localparam logic [3:0] STORE_SP1 = 4'h7;
  localparam logic [3:0] STORE_Q = 4'ha;
  localparam logic [3:0] STORE_F = 4'h9;
  localparam logic [3:0] SPEC_RSS = 4'h0;
  localparam logic [3:0] SPEC_NOP = 4'hf;
  localparam logic [3:0] SKIP_NEG = 4'h3;
  localparam logic [3:0] SKIP_ALU_CARRY_OUT = 4'h4;
  localparam logic [3:0] SKIP_UNC = 4'he;
  localparam logic [3:0] SKIP_NOP = 4'hf;

  // ---------------------------------------------------------------
  // alu levels {mode, fn3, fn2, fn1, fn0, carry-in}
  // ---------------------------------------------------------------
  localparam logic [5:0] ALU_SUB = 6'h0c;
  localparam logic [5:0] ALU_NOR = 6'h23;
  localparam logic [5:0] ALU_IOR = 6'h3d;
  localparam logic [5:0] ALU_IDLE = 6'h3d;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] RST_RBUS = 3'h7;
  localparam logic [3:0] RST_SPEC = 4'hf;
  localparam logic [3:0] RST_SKIP = 4'hf;

endpackage : mfd_pkg

/* rtl/mfd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module mfd_decoder
  import mfd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WORD_W-1:0] instrWord,
  input wire logic instrValid,
  input wire logic aluSignBit,
  input wire logic aluCarryOut,
  output logic execValidQ,
  output logic rbusEnableQ,
  output logic [RBUS_W-1:0] rbusSelQ,
  output logic [2:0] spReadQ,
  output logic spWrite1Q,
  output logic aluModeControlQ,
  output logic aluFuncBit0Q,
  output logic aluFuncBit1Q,
  output logic aluFuncBit2Q,
  output logic aluFuncBit3Q,
  output logic aluCarryInQ,
  output logic qParallelModeSelQ,
  output logic qLoadStrobeQ,
  output logic fParallelModeSelQ,
  output logic fLoadStrobeQ,
  output logic skipSenseReverseQ,
  output logic jumpParallelSelectQ,
  output logic romAddrRegLoadQ,
  output logic specialSkipEnableQ,
  output logic [SPEC_W-1:0] jumpTargetQ,
  output logic skipFlagQ,
  output logic skipTakenQ
);

  // ---------------------------------------------------------------
  // field split
  // ---------------------------------------------------------------
  logic [RBUS_W-1:0] rbusField;
  logic [SBUS_W-1:0] sbusField;
  logic [FUNC_W-1:0] funcField;
  logic [STORE_W-1:0] storeField;
  logic [SPEC_W-1:0] specField;
  logic [SKIP_W-1:0] skipField;

  mfd_field_split uSplit (
    .word(instrWord),
    .rbusField(rbusField),
    .sbusField(sbusField),
    .funcField(funcField),
    .storeField(storeField),
    .specField(specField),
    .skipField(skipField)
  );

  // skip condition test, kept apart so the code table reads in one place
  function automatic logic skipCond(input logic [SKIP_W-1:0] code, input logic reverse,
                                    input logic sign, input logic carry);
    logic hit;
    hit = 1'b0;
    case (code)
      SKIP_NEG: hit = sign ^ reverse;
      SKIP_ALU_CARRY_OUT: hit = carry ^ reverse;
      SKIP_UNC: hit = ~reverse;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ---------------------------------------------------------------
  // skip evaluation and squash
  // ---------------------------------------------------------------
  logic [SKIP_W-1:0] skipCodeQ;
  logic skipHit;
  logic squash;
  logic takeWord;
  logic isJump;

  // the alu flags belong to the word now on the control outputs, so the
  // hit is known in time to squash the very next word at this edge
  assign skipHit = execValidQ & skipCond(skipCodeQ, skipSenseReverseQ, aluSignBit, aluCarryOut);
  assign squash = instrValid & (skipHit | skipFlagQ);
  assign takeWord = instrValid & ~squash;
  assign isJump = (funcField == FUNC_JMP);

  // skip flop: a new hit sets it only while no word is offered; a squashed word clears it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      skipFlagQ <= 1'b0;
    end else if (skipHit && !instrValid) begin
      skipFlagQ <= 1'b1;
    end else if (squash) begin
      skipFlagQ <= 1'b0;
    end
  end

  // one-cycle notice to the sequencer that a word was dropped
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      skipTakenQ <= 1'b0;
    end else begin
      skipTakenQ <= squash;
    end
  end

  // ---------------------------------------------------------------
  // bus source selects
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      execValidQ <= 1'b0;
      rbusEnableQ <= 1'b0;
      rbusSelQ <= RST_RBUS;
      spReadQ <= 3'h0;
    end else begin
      execValidQ <= takeWord;
      rbusEnableQ <= takeWord && (rbusField != RBUS_NOP);
      rbusSelQ <= takeWord ? rbusField : RST_RBUS;
      spReadQ[0] <= takeWord && (sbusField == SBUS_SP1);
      spReadQ[1] <= takeWord && (sbusField == SBUS_SP2);
      spReadQ[2] <= takeWord && (sbusField == SBUS_SP3);
    end
  end

  // ---------------------------------------------------------------
  // alu function levels
  // ---------------------------------------------------------------
  logic [5:0] aluLevels;

  // unknown and squashed words leave the alu in the harmless or function
  always_comb begin
    aluLevels = ALU_IDLE;
    if (takeWord) begin
      case (funcField)
        FUNC_SUB: aluLevels = ALU_SUB;
        FUNC_NOR: aluLevels = ALU_NOR;
        FUNC_IOR: aluLevels = ALU_IOR;
        FUNC_JMP: aluLevels = ALU_IOR;
        default: aluLevels = ALU_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      aluModeControlQ <= ALU_IDLE[5];
      aluFuncBit3Q <= ALU_IDLE[4];
      aluFuncBit2Q <= ALU_IDLE[3];
      aluFuncBit1Q <= ALU_IDLE[2];
      aluFuncBit0Q <= ALU_IDLE[1];
      aluCarryInQ <= ALU_IDLE[0];
    end else begin
      aluModeControlQ <= aluLevels[5];
      aluFuncBit3Q <= aluLevels[4];
      aluFuncBit2Q <= aluLevels[3];
      aluFuncBit1Q <= aluLevels[2];
      aluFuncBit0Q <= aluLevels[1];
      aluCarryInQ <= aluLevels[0];
    end
  end

  // ---------------------------------------------------------------
  // store destinations
  // ---------------------------------------------------------------
  // mode select and strobe come from one compare so they never split
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      qParallelModeSelQ <= 1'b0;
      qLoadStrobeQ <= 1'b0;
      fParallelModeSelQ <= 1'b0;
      fLoadStrobeQ <= 1'b0;
      spWrite1Q <= 1'b0;
    end else begin
      qParallelModeSelQ <= takeWord && (storeField == STORE_Q);
      qLoadStrobeQ <= takeWord && (storeField == STORE_Q);
      fParallelModeSelQ <= takeWord && (storeField == STORE_F);
      fLoadStrobeQ <= takeWord && (storeField == STORE_F);
      spWrite1Q <= takeWord && (storeField == STORE_SP1);
    end
  end

  // ---------------------------------------------------------------
  // special, skip and jump
  // ---------------------------------------------------------------
  // on a jump the special field is the target, so neither it nor the
  // skip field may act; the held skip code becomes a no-op
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      skipSenseReverseQ <= 1'b0;
      skipCodeQ <= RST_SKIP;
      specialSkipEnableQ <= 1'b0;
      jumpParallelSelectQ <= 1'b0;
      romAddrRegLoadQ <= 1'b0;
      jumpTargetQ <= RST_SPEC;
    end else begin
      skipSenseReverseQ <= takeWord && !isJump && (specField == SPEC_RSS);
      skipCodeQ <= (takeWord && !isJump) ? skipField : SKIP_NOP;
      specialSkipEnableQ <= takeWord && !isJump;
      jumpParallelSelectQ <= takeWord && isJump;
      romAddrRegLoadQ <= takeWord && isJump;
      jumpTargetQ <= (takeWord && isJump) ? specField : RST_SPEC;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_sub_levels: assert property (takeWord && funcField == FUNC_SUB |=>
    !aluModeControlQ && !aluFuncBit0Q && aluFuncBit1Q && aluFuncBit2Q && !aluFuncBit3Q && !aluCarryInQ)
    else $error("subtract levels wrong");

  chk_q_store: assert property (takeWord && storeField == STORE_Q |=> qParallelModeSelQ && qLoadStrobeQ)
    else $error("q store not paired");

  chk_f_store: assert property (takeWord && storeField == STORE_F |=> fParallelModeSelQ && fLoadStrobeQ)
    else $error("f store not paired");

  chk_reverse_neg: assert property (execValidQ && skipSenseReverseQ && skipCodeQ == SKIP_NEG && !aluSignBit
    |=> skipFlagQ || skipTakenQ)
    else $error("reversed skip not taken");

  chk_carry_skip: assert property (execValidQ && !skipSenseReverseQ && skipCodeQ == SKIP_ALU_CARRY_OUT && aluCarryOut
    |=> skipFlagQ || skipTakenQ)
    else $error("carry skip not taken");

  chk_neg_skip: assert property (execValidQ && !skipSenseReverseQ && skipCodeQ == SKIP_NEG && aluSignBit
    |=> skipFlagQ || skipTakenQ)
    else $error("negative skip not taken");

  chk_jump_suppress: assert property (takeWord && isJump |=> !skipSenseReverseQ && !specialSkipEnableQ
    ##1 !skipFlagQ && !skipTakenQ)
    else $error("jump did not suppress skip");

  chk_jump_load: assert property (takeWord && isJump |=> romAddrRegLoadQ && jumpParallelSelectQ
    && jumpTargetQ == $past(specField))
    else $error("jump target not loaded");

  chk_skip_drop: assert property (skipFlagQ && instrValid |=> skipTakenQ && !execValidQ
    && !qLoadStrobeQ && !fLoadStrobeQ)
    else $error("skipped word not dropped");

endmodule // mfd_decoder
`default_nettype wire

/* rtl/mfd_field_split.sv */
`timescale 1ns/100ps
`default_nettype none
module mfd_field_split
  import mfd_pkg::*;
(
  input wire logic [WORD_W-1:0] word,
  output logic [RBUS_W-1:0] rbusField,
  output logic [SBUS_W-1:0] sbusField,
  output logic [FUNC_W-1:0] funcField,
  output logic [STORE_W-1:0] storeField,
  output logic [SPEC_W-1:0] specField,
  output logic [SKIP_W-1:0] skipField
);

  // ---------------------------------------------------------------
  // pure wiring: six contiguous fields, R-bus at the top
  // ---------------------------------------------------------------
  assign rbusField = word[RBUS_LSB +: RBUS_W];
  assign sbusField = word[SBUS_LSB +: SBUS_W];
  assign funcField = word[FUNC_LSB +: FUNC_W];
  assign storeField = word[STORE_LSB +: STORE_W];
  assign specField = word[SPEC_LSB +: SPEC_W];
  assign skipField = word[SKIP_LSB +: SKIP_W];

endmodule // mfd_field_split
`default_nettype wire

/* sim/mfd_alu_flag_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// alu flag source standing in for the datapath
// ---------------------------------------------------------------
module mfd_alu_flag_model (
  input wire logic sys_clk,
  input wire logic execValidQ,
  input wire logic wantSign,
  input wire logic wantCarry,
  output logic aluSignBit,
  output logic aluCarryOut
);
  logic churnQ = 1'b0;

  // flags mean nothing without a word on the controls, so they churn to expose stale sampling
  always @(posedge sys_clk) begin
    churnQ <= ~churnQ;
  end

  // flags follow the bench only while a decoded word drives the alu
  assign aluSignBit = execValidQ ? wantSign : churnQ;
  assign aluCarryOut = execValidQ ? wantCarry : ~churnQ;
endmodule // mfd_alu_flag_model
`default_nettype wire

/* sim/microword_field_decoder_test.sv */
`timescale 1ns/100ps
`default_nettype none
module microword_field_decoder_test;
  import mfd_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, wiring and bookkeeping
  // ---------------------------------------------------------------
  localparam logic [23:0] W_SUBQ = 24'hf65af4;
  localparam logic [23:0] W_NORF = 24'hf2d9fe;
  localparam logic [23:0] W_RSS = 24'hf5f703;
  localparam logic [23:0] W_NOP = {RBUS_NOP, 4'hf, FUNC_IOR, 4'hf, SPEC_NOP, SKIP_NOP};
  localparam logic [23:0] W_JMP = {3'h4, 4'hf, FUNC_JMP, 4'hf, SPEC_RSS, SKIP_UNC};
  localparam logic [23:0] W_NEG = {3'h3, SBUS_SP2, FUNC_SUB, 4'hf, SPEC_NOP, SKIP_NEG};
  localparam logic [23:0] W_RCOUT = {RBUS_NOP, 4'hf, FUNC_IOR, 4'hf, SPEC_RSS, SKIP_ALU_CARRY_OUT};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [23:0] instrWord = '0;
  logic instrValid = 1'b0;
  logic wantSign = 1'b0;
  logic wantCarry = 1'b0;
  logic aluSignBit, aluCarryOut, execValidQ, rbusEnableQ, spWrite1Q;
  logic [2:0] rbusSelQ, spReadQ;
  logic aluModeControlQ, aluFuncBit0Q, aluFuncBit1Q, aluFuncBit2Q, aluFuncBit3Q, aluCarryInQ;
  logic qParallelModeSelQ, qLoadStrobeQ, fParallelModeSelQ, fLoadStrobeQ, skipSenseReverseQ;
  logic jumpParallelSelectQ, romAddrRegLoadQ, specialSkipEnableQ, skipFlagQ, skipTakenQ;
  logic [3:0] jumpTargetQ;
  logic [5:0] aluLevels;
  int mismatches = 0;
  int checks_done = 0;

  assign aluLevels = {aluModeControlQ, aluFuncBit3Q, aluFuncBit2Q, aluFuncBit1Q, aluFuncBit0Q, aluCarryInQ};

  // half period of 12.5 ns gives 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  mfd_decoder dut (.sys_clk(sys_clk), .reset(reset), .instrWord(instrWord), .instrValid(instrValid),
    .aluSignBit(aluSignBit), .aluCarryOut(aluCarryOut), .execValidQ(execValidQ), .rbusEnableQ(rbusEnableQ),
    .rbusSelQ(rbusSelQ), .spReadQ(spReadQ), .spWrite1Q(spWrite1Q), .aluModeControlQ(aluModeControlQ),
    .aluFuncBit0Q(aluFuncBit0Q), .aluFuncBit1Q(aluFuncBit1Q), .aluFuncBit2Q(aluFuncBit2Q),
    .aluFuncBit3Q(aluFuncBit3Q), .aluCarryInQ(aluCarryInQ), .qParallelModeSelQ(qParallelModeSelQ),
    .qLoadStrobeQ(qLoadStrobeQ), .fParallelModeSelQ(fParallelModeSelQ), .fLoadStrobeQ(fLoadStrobeQ),
    .skipSenseReverseQ(skipSenseReverseQ), .jumpParallelSelectQ(jumpParallelSelectQ),
    .romAddrRegLoadQ(romAddrRegLoadQ), .specialSkipEnableQ(specialSkipEnableQ), .jumpTargetQ(jumpTargetQ),
    .skipFlagQ(skipFlagQ), .skipTakenQ(skipTakenQ));

  mfd_alu_flag_model partner (.sys_clk(sys_clk), .execValidQ(execValidQ), .wantSign(wantSign),
    .wantCarry(wantCarry), .aluSignBit(aluSignBit), .aluCarryOut(aluCarryOut));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // inputs always move 1 ns after the edge so sampling never races
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic idle_in_reset();
    chk(execValidQ === 1'b0 && aluLevels === ALU_IDLE, "reset alu levels");
    chk(rbusSelQ === RST_RBUS && jumpTargetQ === RST_SPEC && skipFlagQ === 1'b0, "reset fields");
  endtask

  // subtract into q, carry out skips the very next word offered back to back
  task automatic sub_q_carry_skip();
    instrWord = W_SUBQ;
    instrValid = 1'b1;
    tick();
    chk(execValidQ === 1'b1 && spReadQ === 3'h1 && rbusEnableQ === 1'b0, "sub fields");
    chk(aluLevels === ALU_SUB, "sub levels");
    chk(qParallelModeSelQ === 1'b1 && qLoadStrobeQ === 1'b1 && fLoadStrobeQ === 1'b0, "q store");
    wantCarry = 1'b1;
    instrWord = W_NOP;
    tick();
    chk(execValidQ === 1'b0 && skipTakenQ === 1'b1 && qLoadStrobeQ === 1'b0, "carry skip");
    instrValid = 1'b0;
    wantCarry = 1'b0;
    tick();
    chk(skipFlagQ === 1'b0 && skipTakenQ === 1'b0, "skip cleared");
  endtask

  // unconditional skip with no word waiting leaves the flop pending
  task automatic nor_f_pending_skip();
    instrWord = W_NORF;
    instrValid = 1'b1;
    tick();
    chk(fParallelModeSelQ === 1'b1 && fLoadStrobeQ === 1'b1 && qLoadStrobeQ === 1'b0, "f store");
    chk(aluLevels === ALU_NOR && spReadQ === 3'h4, "nor fields");
    instrValid = 1'b0;
    tick();
    chk(skipFlagQ === 1'b1 && execValidQ === 1'b0, "flop pending");
    instrWord = W_NOP;
    instrValid = 1'b1;
    tick();
    chk(skipTakenQ === 1'b1 && execValidQ === 1'b0 && skipFlagQ === 1'b0, "pending drop");
    tick();
    chk(execValidQ === 1'b1 && skipTakenQ === 1'b0, "next word runs");
    instrValid = 1'b0;
    tick();
  endtask

  // reversed sense: skip only while the sign bit is clear
  task automatic reverse_sense(input logic sign, input logic expSkip);
    instrWord = W_RSS;
    instrValid = 1'b1;
    tick();
    chk(skipSenseReverseQ === 1'b1 && spWrite1Q === 1'b1 && aluLevels === ALU_IOR, "rss word");
    chk(spReadQ === 3'h2 && rbusEnableQ === 1'b0 && specialSkipEnableQ === 1'b1, "rss fields");
    wantSign = sign;
    instrWord = W_NOP;
    tick();
    chk(skipTakenQ === expSkip && execValidQ === !expSkip, "rss outcome");
    instrValid = 1'b0;
    wantSign = 1'b0;
    tick();
  endtask

  // jump carries reverse and unconditional codes that must both be ignored
  task automatic jump_suppress();
    instrWord = W_JMP;
    instrValid = 1'b1;
    tick();
    chk(jumpParallelSelectQ === 1'b1 && romAddrRegLoadQ === 1'b1 && jumpTargetQ === SPEC_RSS, "jump");
    chk(skipSenseReverseQ === 1'b0 && specialSkipEnableQ === 1'b0, "jump special");
    chk(rbusEnableQ === 1'b1 && rbusSelQ === 3'h4 && aluLevels === ALU_IOR, "jump fields");
    instrWord = W_NOP;
    tick();
    chk(execValidQ === 1'b1 && skipTakenQ === 1'b0, "jump no skip");
    chk(romAddrRegLoadQ === 1'b0 && jumpParallelSelectQ === 1'b0 && jumpTargetQ === RST_SPEC, "jump ends");
    instrValid = 1'b0;
    tick();
  endtask

  // plain negative code skips on the sign bit; reversed carry code holds back on carry
  task automatic sense_variants();
    instrWord = W_NEG;
    instrValid = 1'b1;
    tick();
    chk(spReadQ === 3'h2 && rbusEnableQ === 1'b1 && rbusSelQ === 3'h3 && aluLevels === ALU_SUB, "neg fields");
    chk(specialSkipEnableQ === 1'b1 && skipSenseReverseQ === 1'b0 && romAddrRegLoadQ === 1'b0, "neg special");
    chk(jumpTargetQ === RST_SPEC && qLoadStrobeQ === 1'b0 && fLoadStrobeQ === 1'b0, "neg no store");
    wantSign = 1'b1;
    instrWord = W_NOP;
    tick();
    chk(skipTakenQ === 1'b1 && execValidQ === 1'b0, "neg skip");
    wantSign = 1'b0;
    instrWord = W_RCOUT;
    tick();
    chk(execValidQ === 1'b1 && skipSenseReverseQ === 1'b1, "rcout word");
    wantCarry = 1'b1;
    instrWord = W_NOP;
    tick();
    chk(execValidQ === 1'b1 && skipTakenQ === 1'b0, "reversed carry holds");
    instrValid = 1'b0;
    wantCarry = 1'b0;
    tick();
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    idle_in_reset();
    reset = 1'b0;
    tick();
    idle_in_reset();
    sub_q_carry_skip();
    nor_f_pending_skip();
    reverse_sense(1'b0, 1'b1);
    reverse_sense(1'b1, 1'b0);
    jump_suppress();
    sense_variants();
    give_verdict();
  end

  // the scenarios need about 30 cycles, so 2000 only trips on a hang
  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
endmodule // microword_field_decoder_test
`default_nettype wire
